//--- bench/ddrtc_ctl_model.sv
// ddrtc_ctl_model: controller stand-in driving write commands
// assumes one clock shared with the block
`timescale 1ns/1ns
`default_nettype none
module ddrtc_ctl_model (
  // clock
  input wire logic clk_i,
  // requests from the bench
  input wire logic issue_i,
  input wire logic otf_i,
  // command pins toward the block
  output logic wr_cmd_o,
  output logic bc4_otf_o
);
  // registered, so a one-cycle request gives a one-cycle command
  // only plain writes go out: no mrs, cke, dll or geardown traffic to space
  always_ff @(posedge clk_i) begin
    wr_cmd_o <= issue_i;
    bc4_otf_o <= otf_i;
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// tb: register, rounding, write start and preamble tests
// assumes the block answers each bus cycle with a one-cycle ack
`timescale 1ns/1ns
`default_nettype none
module tb
  import ddrtc_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, issue, otf, wr_cmd, bc4_otf, wr_start, lead;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q, e;
  logic [1:0] pre;
  int bad_count, check_count, cycles, n;
  int pv[4] = '{13750, 14060, 15000, 5000};
  int tv[4] = '{1250, 937, 1000, 833};
  ddrtc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .wr_cmd_i(wr_cmd), .bc4_otf_i(bc4_otf), .wr_start_o(wr_start),
    .rd_strobe_lead_o(lead), .wr_preamble_clk_o(pre));
  ddrtc_ctl_model ctl (.clk_i(clk_i), .issue_i(issue), .otf_i(otf),
    .wr_cmd_o(wr_cmd), .bc4_otf_o(bc4_otf));
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; cyc drops for a cycle before the next one
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // own integer rounding, optional round-up to even
  function automatic logic [31:0] ncyc(input logic [63:0] p, input logic [63:0] t,
      input logic ev);
    logic [63:0] r;
    r = (p * 64'h3E8 / t + 64'h3CE) / 64'h3E8;
    if (ev && r[0]) r = r + 64'h1;
    return r[31:0];
  endfunction
  // real-math form of the same rounding, kept apart from the integer one
  function automatic logic [31:0] ncyc_real(input int p, input int t, input logic ev);
    int r;
    r = $rtoi($ceil(real'(p) / real'(t) - 0.025));
    if (ev && r[0]) r = r + 1;
    return 32'(r);
  endfunction
  task automatic conv(input logic [31:0] p, input logic [31:0] t, input logic ev);
    wb(1'b1, DDRTC_OFS_PARAM, p);
    wb(1'b1, DDRTC_OFS_TCK, t);
    wb(1'b1, DDRTC_OFS_CTRL, 32'h1 | (32'(ev) << DDRTC_CTRL_EVEN));
    for (int i = 0; i < 20; i++) begin
      wb(1'b0, DDRTC_OFS_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    check(32'(q[0]), 32'h0);
  endtask
  // bench issues one write command, then counts edges to the start pulse
  task automatic wcmd(input logic o);
    @(posedge clk_i);
    issue <= 1'b1;
    otf <= o;
    @(posedge clk_i);
    issue <= 1'b0;
    @(posedge clk_i);
    n = 0;
    while (n < 30) begin
      @(posedge clk_i);
      n++;
      if (wr_start === 1'b1) break;
    end
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    issue = 1'b0;
    otf = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(pre), 32'h1);
    check(32'(lead), 32'h0);
    wb(1'b0, DDRTC_OFS_CTRL, 32'h0);
    check(q, DDRTC_CTRL_RST);
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 32'h0);
    check(q, 32'h0);
    for (int k = 0; k < 8; k++) begin
      conv(pv[k % 4], tv[k % 4], k >= 4);
      wb(1'b0, DDRTC_OFS_RESULT, 32'h0);
      e = ncyc(pv[k % 4], tv[k % 4], k >= 4);
      check(q, e);
      check(q, ncyc_real(pv[k % 4], tv[k % 4], k >= 4));
    end
    conv(32'd5000, 32'h0, 1'b0);
    check(q & 32'h2, 32'h2);
    wb(1'b0, DDRTC_OFS_RESULT, 32'h0);
    check(q, e);
    wb(1'b1, DDRTC_OFS_CTRL, 32'h5A);
    check(32'(lead), 32'h1);
    check(32'(pre), 32'h2);
    wb(1'b0, DDRTC_OFS_CTRL, 32'h0);
    check(q, 32'h5A);
    wb(1'b1, DDRTC_OFS_CTRL, 32'h18);
    check(32'(lead), 32'h0);
    check(32'(pre), 32'h1);
    for (int w = 0; w < 4; w += 3) begin
      wb(1'b1, DDRTC_OFS_WL, 32'(w));
      wb(1'b1, DDRTC_OFS_CTRL, 32'h0);
      wcmd(1'b0);
      check(n, w + 5);
      wcmd(1'b1);
      check(n, w + 5);
      wb(1'b1, DDRTC_OFS_CTRL, 32'h20);
      wcmd(1'b0);
      check(n, w + 3);
    end
    summarize();
  end
endmodule
`default_nettype wire

//--- core/ddrtc_conv.sv
// ddrtc_conv: picosecond to clock-count rounding, one cycle latency
// assumes start is a one-cycle pulse with stable operands
`timescale 1ns/1ns
`default_nettype none
module ddrtc_conv
  import ddrtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request and answer
  ddrtc_conv_if.conv c
);
  logic done_ff, nxt_done;
  logic inv_ff, nxt_inv;
  logic [31:0] ncyc_ff, nxt_ncyc;
  logic [63:0] prod;
  logic [63:0] quot;

  always_comb begin
    prod = {32'h0000_0000, c.param_ps} * DDRTC_SCALE;
    // divide guarded so a zero period never reaches the divider
    quot = (c.tck_ps == 32'h0000_0000) ? 64'h0 :
      (prod / {32'h0000_0000, c.tck_ps} + DDRTC_INV_CORR) / DDRTC_SCALE;
    nxt_done = c.start;
    nxt_inv = c.start ? (c.tck_ps == 32'h0000_0000) : inv_ff;
    nxt_ncyc = ncyc_ff;
    if (c.start && c.tck_ps != 32'h0000_0000) begin
      nxt_ncyc = quot[31:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
      inv_ff <= 1'b0;
      ncyc_ff <= DDRTC_DATA_RST;
    end else begin
      done_ff <= nxt_done;
      inv_ff <= nxt_inv;
      ncyc_ff <= nxt_ncyc;
    end
  end

  assign c.done = done_ff;
  assign c.invalid = inv_ff;
  assign c.ncyc = ncyc_ff;

  answer_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c.start |=> c.done) else $error("no answer one cycle after start");
  zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c.start && c.tck_ps == 32'h0 |=> c.invalid && $stable(c.ncyc))
    else $error("zero period not flagged");
  round_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    c.start && c.tck_ps != 32'h0 && c.param_ps < 32'h0010_0000 |=>
    (c.ncyc * $past(c.tck_ps)) * 64'h3E8 + 64'h1A * $past(c.tck_ps)
      >= 64'h3E8 * $past(c.param_ps))
    else $error("count too small for parameter");
endmodule
`default_nettype wire

//--- core/ddrtc_top.sv
// ddrtc_top: timing rounding, write start, preamble and read strobe lead
// assumes classic Wishbone master; controller honours its own spacings
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ddrtc_top
  import ddrtc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // write start and strobe timing
  input wire logic wr_cmd_i,
  input wire logic bc4_otf_i,
  output logic wr_start_o,
  output logic rd_strobe_lead_o,
  output logic [1:0] wr_preamble_clk_o
);
  ddrtc_conv_if cif();

  ddrtc_conv u_conv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .c(cif.conv)
  );

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] param_ff, nxt_param;
  logic [31:0] tck_ff, nxt_tck;
  logic [31:0] res_ff, nxt_res;
  logic [7:0] wl_ff, nxt_wl;
  logic busy_ff, nxt_busy;
  logic inv_ff, nxt_inv;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic start_ff, nxt_start;
  logic [15:0] wcnt_ff, nxt_wcnt;
  logic wact_ff, nxt_wact;
  logic wst_ff, nxt_wst;
  logic req;
  logic [31:0] wl_merge;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req = cyc_i && stb_i && !ack_ff;

  // register file and conversion launch
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_param = param_ff;
    nxt_tck = tck_ff;
    nxt_wl = wl_ff;
    nxt_res = res_ff;
    nxt_busy = busy_ff;
    nxt_inv = inv_ff;
    nxt_start = 1'b0;
    nxt_ack = req;
    nxt_rdat = rdat_ff;
    wl_merge = lane_merge({24'h0, wl_ff}, dat_i, sel_i);
    if (req && we_i) begin
      case (adr_i)
        DDRTC_OFS_CTRL: begin
          nxt_ctrl = lane_merge(ctrl_ff, dat_i, sel_i);
          // start bit self-clears; launch only when idle
          if (sel_i[0] && dat_i[DDRTC_CTRL_START] && !busy_ff) begin
            nxt_start = 1'b1;
            nxt_busy = 1'b1;
          end
          nxt_ctrl[DDRTC_CTRL_START] = 1'b0;
        end
        DDRTC_OFS_PARAM: nxt_param = lane_merge(param_ff, dat_i, sel_i);
        DDRTC_OFS_TCK: nxt_tck = lane_merge(tck_ff, dat_i, sel_i);
        DDRTC_OFS_WL: nxt_wl = wl_merge[7:0];
        default: ;
      endcase
    end
    if (cif.done) begin
      nxt_busy = 1'b0;
      nxt_inv = cif.invalid;
      if (!cif.invalid) begin
        nxt_res = cif.ncyc;
        // geardown-type parameters must land on an even count
        if (ctrl_ff[DDRTC_CTRL_EVEN] && cif.ncyc[0]) begin
          nxt_res = cif.ncyc + 32'h1;
        end
      end
    end
    if (req && !we_i) begin
      case (adr_i)
        DDRTC_OFS_CTRL: nxt_rdat = ctrl_ff;
        DDRTC_OFS_PARAM: nxt_rdat = param_ff;
        DDRTC_OFS_TCK: nxt_rdat = tck_ff;
        DDRTC_OFS_RESULT: nxt_rdat = res_ff;
        DDRTC_OFS_WL: nxt_rdat = {24'h0, wl_ff};
        DDRTC_OFS_STATUS: nxt_rdat = {30'h0, inv_ff, busy_ff};
        default: nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= DDRTC_CTRL_RST;
      param_ff <= DDRTC_DATA_RST;
      tck_ff <= DDRTC_DATA_RST;
      res_ff <= DDRTC_DATA_RST;
      wl_ff <= 8'h00;
      busy_ff <= 1'b0;
      inv_ff <= 1'b0;
      start_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= DDRTC_DATA_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      param_ff <= nxt_param;
      tck_ff <= nxt_tck;
      res_ff <= nxt_res;
      wl_ff <= nxt_wl;
      busy_ff <= nxt_busy;
      inv_ff <= nxt_inv;
      start_ff <= nxt_start;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign cif.start = start_ff;
  assign cif.param_ps = param_ff;
  assign cif.tck_ps = tck_ff;
  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // internal write start; one write tracked at a time
  always_comb begin
    nxt_wcnt = wcnt_ff;
    nxt_wact = wact_ff;
    nxt_wst = 1'b0;
    if (wr_cmd_i && !wact_ff) begin
      nxt_wact = 1'b1;
      if (ctrl_ff[DDRTC_CTRL_BCFIX]) begin
        nxt_wcnt = {8'h00, wl_ff} + {8'h00, DDRTC_WSTART_BC4FIX};
      end else begin
        nxt_wcnt = {8'h00, wl_ff} + {8'h00, DDRTC_WSTART_BL8};
      end
    end else if (wact_ff) begin
      // a tracked write always runs out; a new command cannot cut it short
      if (wcnt_ff <= 16'h0001) begin
        nxt_wact = 1'b0;
        nxt_wst = 1'b1;
      end else begin
        nxt_wcnt = wcnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wcnt_ff <= 16'h0000;
      wact_ff <= 1'b0;
      wst_ff <= 1'b0;
    end else begin
      wcnt_ff <= nxt_wcnt;
      wact_ff <= nxt_wact;
      wst_ff <= nxt_wst;
    end
  end

  assign wr_start_o = wst_ff;
  // two-clock modes only honoured at the faster grades
  assign rd_strobe_lead_o = ctrl_ff[DDRTC_CTRL_RDPRE] && ctrl_ff[DDRTC_CTRL_SPD2400];
  assign wr_preamble_clk_o = (ctrl_ff[DDRTC_CTRL_WRPRE] && ctrl_ff[DDRTC_CTRL_SPD2400])
    ? 2'h2 : 2'h1;

  sequence wr_taken_s;
    wr_cmd_i && !wact_ff && !ctrl_ff[DDRTC_CTRL_BCFIX] && wl_ff == 8'h00;
  endsequence
  bl8_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_taken_s |-> ##5 wr_start_o) else $error("bl8 write start late");
  bc4_fix_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd_i && !wact_ff && ctrl_ff[DDRTC_CTRL_BCFIX] && wl_ff == 8'h00
    |-> ##3 wr_start_o) else $error("fixed bc4 write start wrong");
  otf_bc4_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd_i && bc4_otf_i && !wact_ff && !ctrl_ff[DDRTC_CTRL_BCFIX] && wl_ff == 8'h00
    |-> ##5 wr_start_o) else $error("otf bc4 write start wrong");
  even_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.done && !cif.invalid && ctrl_ff[DDRTC_CTRL_EVEN] |=> !res_ff[0])
    else $error("geardown count odd");
  zero_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cif.done && cif.invalid |=> inv_ff && $stable(res_ff))
    else $error("result changed for zero period");
  rd_lead_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_strobe_lead_o |-> ctrl_ff[DDRTC_CTRL_RDPRE])
    else $error("strobe lead without a11");
  wr_pre_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_ff[DDRTC_CTRL_WRPRE] |-> wr_preamble_clk_o == 2'h1)
    else $error("write preamble not one clock");
  conv_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ff |=> cif.done ##1 !busy_ff) else $error("conversion late");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
endmodule
`default_nettype wire

//--- include/ddrtc_conv_if.sv
// ddrtc_conv_if: request/answer between register file and the converter
// assumes one clock for both sides
`timescale 1ns/1ns
`default_nettype none
interface ddrtc_conv_if;
  logic start;
  logic [31:0] param_ps;
  logic [31:0] tck_ps;
  logic done;
  logic invalid;
  logic [31:0] ncyc;
  modport req (output start, output param_ps, output tck_ps,
    input done, input invalid, input ncyc);
  modport conv (input start, input param_ps, input tck_ps,
    output done, output invalid, output ncyc);
endinterface
`default_nettype wire

//--- include/ddrtc_pkg.sv
// ddrtc_pkg: constants shared by the timing cycle rounding block
// assumes a Wishbone classic slave with 32-bit data
package ddrtc_pkg;
  // register byte offsets
  localparam logic [7:0] DDRTC_OFS_CTRL = 8'h00;
  localparam logic [7:0] DDRTC_OFS_PARAM = 8'h04;
  localparam logic [7:0] DDRTC_OFS_TCK = 8'h08;
  localparam logic [7:0] DDRTC_OFS_RESULT = 8'h0C;
  localparam logic [7:0] DDRTC_OFS_WL = 8'h10;
  localparam logic [7:0] DDRTC_OFS_STATUS = 8'h14;
  // ctrl field positions
  localparam int DDRTC_CTRL_START = 0;
  localparam int DDRTC_CTRL_CRCDM = 1;
  localparam int DDRTC_CTRL_EVEN = 2;
  localparam int DDRTC_CTRL_RDPRE = 3;
  localparam int DDRTC_CTRL_WRPRE = 4;
  localparam int DDRTC_CTRL_BCFIX = 5;
  localparam int DDRTC_CTRL_SPD2400 = 6;
  // reset values
  localparam logic [31:0] DDRTC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DDRTC_DATA_RST = 32'h0000_0000;
  // rounding constants
  localparam logic [63:0] DDRTC_SCALE = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] DDRTC_INV_CORR = 64'h0000_0000_0000_03CE;
  // write start offsets after write latency
  localparam logic [7:0] DDRTC_WSTART_BL8 = 8'h04;
  localparam logic [7:0] DDRTC_WSTART_BC4FIX = 8'h02;
endpackage
